// ===== src/fll_pkg.sv
// shared constants, types and register map of the frequency-locked-loop supervisor
package fll_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned BAUD_RATE      = 4800;
  localparam int unsigned BAUD_DIV       = 1_000_000_000 / (CLK_PERIOD_NS * BAUD_RATE);
  localparam int unsigned PPS_PER_SAMPLE = 16;
  localparam int unsigned FRAME_BITS     = 10;
  localparam int unsigned LINE_CHARS     = 38;

  // loop numbers
  localparam logic [15:0] NOMINAL     = 16'h6800;
  localparam logic [13:0] DAC_MAX     = 14'h3FFF;
  localparam logic [13:0] DAC_RST     = 14'h2000;
  localparam logic [13:0] STEP_COARSE = 14'h0010;
  localparam logic [13:0] STEP_FINE   = 14'h0001;
  localparam logic [15:0] ACC_ONE     = 16'h0001;

  // register byte addresses
  localparam int unsigned AXI_AW   = 8;
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_CYCLE = 8'h08;
  localparam logic [7:0] REG_THR   = 8'h0C;
  localparam logic [7:0] REG_DAC   = 8'h10;
  localparam logic [7:0] REG_STAT  = 8'h14;
  localparam logic [7:0] REG_MEAS  = 8'h18;

  // fields and reset values
  localparam int unsigned CTRL_GATE  = 0;
  localparam int unsigned CTRL_SUM   = 1;
  localparam int unsigned CTRL_MAN   = 2;
  localparam int unsigned CMD_ACLR   = 0;
  localparam int unsigned CMD_SCLR   = 1;
  localparam int unsigned THR_F_LSB  = 0;
  localparam int unsigned THR_L_LSB  = 8;
  localparam int unsigned THR_H_LSB  = 16;
  localparam int unsigned THR_W_LSB  = 24;
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [15:0] CYCLE_RST  = 16'h0200;
  localparam logic [31:0] THR_RST    = 32'hC8080408;
  localparam int unsigned AL_UNLK    = 0;
  localparam int unsigned AL_BOT     = 1;
  localparam int unsigned AL_TOP     = 2;
  localparam int unsigned AL_HOLD    = 3;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  // characters
  localparam logic [7:0] CH_L = 8'h4C, CH_U = 8'h55, CH_H = 8'h48, CH_D = 8'h44;
  localparam logic [7:0] CH_B = 8'h42, CH_T = 8'h54, CH_C = 8'h43, CH_F = 8'h46;
  localparam logic [7:0] CH_DOT = 8'h2E, CH_PLUS = 8'h2B, CH_MINUS = 8'h2D, CH_EQ = 8'h3D;
  localparam logic [7:0] CH_SP = 8'h20, CH_CR = 8'h0D, CH_LF = 8'h0A;
  localparam logic [7:0] CH_0 = 8'h30, CH_A = 8'h41;

  typedef enum logic [1:0] {
    ST_UNLOCKED = 2'b00, ST_LOCKED = 2'b01, ST_HOLDOVER = 2'b10, ST_DISABLED = 2'b11
  } fll_state_t;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;
endpackage

// ===== src/gps_fll_status_and_control.sv
// frequency-locked-loop supervisor with status line transmitter and register slave
// Overview of operation
// - send one status line every sample
// - serial 4800 baud, 8N1, no flow control
// - hex ASCII fields, line ends CR LF
// - loop state char L, U, H, D
// - alarms stay latched until alarm clear
// - alarm chars U, B, T, H; else period
// - DAC is 14 bits, shown as five hex
// - direction +, -, = at cycle end unless disabled, else period
// - coarse step 16 C, fine step 1 F
// - readout is 16-bit count, nominal 0x6800
// - cycle ends when sample count reaches size
// - accumulated difference is signed two's complement
// - summing mode adds signed sample difference
// - voting mode adds or subtracts one
// - free-running 16-bit timestamp, no loop effect
// - holdover counter counts samples in holdover
// - holdover counter at wait limit goes unlocked
// - lock threshold met only when strictly below
// - gating disables outputs only while not locked/holdover
// - gating off by default, on when selected
// - LED flashes red while any alarm latched
// - locked sample at or beyond holdover limit enters holdover
// - unlocked cycle end under lock limit locks
// - holdover counter zeroed on holdover entry
// - coarse step when difference reaches coarse threshold
`timescale 1ns/1ns
module gps_fll_status_and_control
  import fll_pkg::*;
#(
  parameter int unsigned BAUD_DIV_P = BAUD_DIV
) (
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     resetn,
  // register bus
  input  wire axi_req_t axi_req,
  output axi_rsp_t      axi_rsp,
  // timing pins
  input  wire logic     pps_pin,
  input  wire logic     osc_pin,
  // tuning and outputs
  output logic [13:0]   dac_value,
  output logic          ref_out_en,
  output logic          led_red,
  output logic          led_green,
  output logic          txd
);

  if (BAUD_DIV_P < 2 || BAUD_DIV_P > 65535) begin : g_bad_baud
    $error("baud divider out of range");
  end

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? CH_0 + {4'h0, n} : CH_A + {4'h0, n - 4'hA};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // pin synchronisers: stage 0 feeds only stage 1
  logic [2:0] pps_s_q, pps_s_d, osc_s_q, osc_s_d;
  always_comb begin
    pps_s_d = {pps_s_q[1:0], pps_pin};
    osc_s_d = {osc_s_q[1:0], osc_pin};
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pps_s_q <= 3'h0;
      osc_s_q <= 3'h0;
    end else begin
      pps_s_q <= pps_s_d;
      osc_s_q <= osc_s_d;
    end
  end
  logic pps_rise, osc_rise;
  assign pps_rise = pps_s_q[1] & ~pps_s_q[2];
  assign osc_rise = osc_s_q[1] & ~osc_s_q[2];

  // sample window: count reference edges over sixteen pulses, low 16 bits kept
  logic [15:0] osc_cnt_q, osc_cnt_d, freq_q, freq_d;
  logic [3:0]  pps_idx_q, pps_idx_d;
  logic        samp_q, samp_d, flash_q, flash_d;
  always_comb begin
    osc_cnt_d = osc_rise ? osc_cnt_q + 16'h0001 : osc_cnt_q;
    pps_idx_d = pps_idx_q;
    freq_d    = freq_q;
    samp_d    = 1'b0;
    flash_d   = flash_q ^ pps_rise;
    if (pps_rise) begin
      pps_idx_d = pps_idx_q + 4'h1;
      if (pps_idx_q == 4'(PPS_PER_SAMPLE - 1)) begin
        freq_d    = osc_cnt_d;
        osc_cnt_d = 16'h0000;
        samp_d    = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      osc_cnt_q <= 16'h0000;
      pps_idx_q <= 4'h0;
      freq_q    <= NOMINAL;
      samp_q    <= 1'b0;
      flash_q   <= 1'b0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
      pps_idx_q <= pps_idx_d;
      freq_q    <= freq_d;
      samp_q    <= samp_d;
      flash_q   <= flash_d;
    end
  end

  // configuration, written over the bus
  logic [2:0]  ctrl_q;
  logic [15:0] cycle_q;
  logic [31:0] thr_q;
  logic        aclr_q, sclr_q, dacwr_q;
  logic [13:0] dacw_q;

  // loop state
  fll_state_t         state_q, state_d;
  logic signed [15:0] acc_q, acc_d, acc_n, diff;
  logic [15:0]        scnt_q, scnt_d, ts_q, ts_d, absd, absa;
  logic [7:0]         hcnt_q, hcnt_d, sign_q, sign_d, size_q, size_d;
  logic [13:0]        dac_q, dac_d, step;
  logic [3:0]         alarm_q, alarm_d, aset;
  logic [14:0]        dac_up;
  logic               cyc_end, snap_q;

  always_comb begin
    diff    = signed'(freq_q - NOMINAL);
    absd    = diff[15] ? 16'(-diff) : 16'(diff);
    if (ctrl_q[CTRL_SUM]) begin
      acc_n = acc_q + diff;
    end else if (diff > 0) begin
      acc_n = acc_q + signed'(ACC_ONE);
    end else if (diff < 0) begin
      acc_n = acc_q - signed'(ACC_ONE);
    end else begin
      acc_n = acc_q;
    end
    absa    = acc_n[15] ? 16'(-acc_n) : 16'(acc_n);
    cyc_end = (scnt_q + 16'h0001) >= cycle_q;
    step    = (absa >= {8'h00, thr_q[THR_F_LSB +: 8]}) ? STEP_COARSE : STEP_FINE;
    dac_up  = {1'b0, dac_q} + {1'b0, step};
    state_d = state_q;
    acc_d   = acc_q;
    scnt_d  = sclr_q ? 16'h0000 : scnt_q;
    ts_d    = ts_q;
    hcnt_d  = hcnt_q;
    sign_d  = sign_q;
    size_d  = size_q;
    dac_d   = (dacwr_q && state_q == ST_DISABLED) ? dacw_q : dac_q;
    aset    = 4'h0;
    if (samp_q) begin
      ts_d   = ts_q + 16'h0001;
      sign_d = CH_DOT;
      size_d = CH_DOT;
      acc_d  = acc_n;
      scnt_d = scnt_q + 16'h0001;
      if (cyc_end) begin
        acc_d  = 16'sh0000;
        scnt_d = 16'h0000;
        if (state_q != ST_DISABLED) begin
          if (acc_n == 0) begin
            sign_d = CH_EQ;
          end else begin
            size_d = (step == STEP_COARSE) ? CH_C : CH_F;
            if (acc_n > 0) begin
              sign_d = CH_MINUS;
              dac_d  = (dac_q <= step) ? 14'h0000 : dac_q - step;
              aset[AL_BOT] = (dac_q <= step);
            end else begin
              sign_d = CH_PLUS;
              dac_d  = (dac_up >= {1'b0, DAC_MAX}) ? DAC_MAX : dac_up[13:0];
              aset[AL_TOP] = (dac_up >= {1'b0, DAC_MAX});
            end
          end
        end
      end
      unique case (state_q)
        ST_UNLOCKED: begin
          if (cyc_end && absa < {8'h00, thr_q[THR_L_LSB +: 8]}) begin
            state_d = ST_LOCKED;
          end
        end
        ST_LOCKED: begin
          if (absd >= {8'h00, thr_q[THR_H_LSB +: 8]}) begin
            state_d = ST_HOLDOVER;
            hcnt_d  = 8'h00;
          end
        end
        ST_HOLDOVER: begin
          if (absd < {8'h00, thr_q[THR_L_LSB +: 8]}) begin
            state_d = ST_LOCKED;
          end else begin
            hcnt_d = hcnt_q + 8'h01;
            if (hcnt_d >= thr_q[THR_W_LSB +: 8]) begin
              state_d       = ST_UNLOCKED;
              aset[AL_HOLD] = 1'b1;
            end
          end
        end
        ST_DISABLED: begin
        end
      endcase
    end
    if (ctrl_q[CTRL_MAN]) begin
      state_d = ST_DISABLED;
    end else if (state_q == ST_DISABLED) begin
      state_d = ST_UNLOCKED;
    end
    aset[AL_UNLK] = (state_d == ST_UNLOCKED) && (state_q != ST_UNLOCKED);
    // a new event beats a clear in the same cycle
    alarm_d = (aclr_q ? 4'h0 : alarm_q) | aset;
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_UNLOCKED;
      acc_q   <= 16'sh0000;
      scnt_q  <= 16'h0000;
      ts_q    <= 16'h0000;
      hcnt_q  <= 8'h00;
      sign_q  <= CH_DOT;
      size_q  <= CH_DOT;
      dac_q   <= DAC_RST;
      alarm_q <= 4'h0;
      snap_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      scnt_q  <= scnt_d;
      ts_q    <= ts_d;
      hcnt_q  <= hcnt_d;
      sign_q  <= sign_d;
      size_q  <= size_d;
      dac_q   <= dac_d;
      alarm_q <= alarm_d;
      snap_q  <= samp_q;
    end
  end

  assign dac_value  = dac_q;
  assign ref_out_en = !ctrl_q[CTRL_GATE] || state_q == ST_LOCKED || state_q == ST_HOLDOVER;
  assign led_red    = (|alarm_q) & flash_q;
  assign led_green  = !(|alarm_q) && state_q == ST_LOCKED;

  // status line, built from the values settled one cycle after the sample
  logic [7:0]             st_ch, al_ch;
  logic [LINE_CHARS*8-1:0] line_v;
  always_comb begin
    unique case (state_q)
      ST_UNLOCKED: st_ch = CH_U;
      ST_LOCKED:   st_ch = CH_L;
      ST_HOLDOVER: st_ch = CH_H;
      ST_DISABLED: st_ch = CH_D;
    endcase
    // only one character fits, so the most severe latched alarm is shown
    if (alarm_q[AL_HOLD]) begin
      al_ch = CH_H;
    end else if (alarm_q[AL_TOP]) begin
      al_ch = CH_T;
    end else if (alarm_q[AL_BOT]) begin
      al_ch = CH_B;
    end else if (alarm_q[AL_UNLK]) begin
      al_ch = CH_U;
    end else begin
      al_ch = CH_DOT;
    end
    line_v = {st_ch, CH_SP, al_ch, CH_SP,
              hx(4'h0), hx({2'b00, dac_q[13:12]}), hx(dac_q[11:8]), hx(dac_q[7:4]), hx(dac_q[3:0]), CH_SP,
              sign_q, CH_SP, size_q, CH_SP,
              hx(freq_q[15:12]), hx(freq_q[11:8]), hx(freq_q[7:4]), hx(freq_q[3:0]), CH_SP,
              hx(scnt_q[15:12]), hx(scnt_q[11:8]), hx(scnt_q[7:4]), hx(scnt_q[3:0]), CH_SP,
              hx(acc_q[15:12]), hx(acc_q[11:8]), hx(acc_q[7:4]), hx(acc_q[3:0]), CH_SP,
              hx(ts_q[15:12]), hx(ts_q[11:8]), hx(ts_q[7:4]), hx(ts_q[3:0]), CH_SP,
              hx(hcnt_q[7:4]), hx(hcnt_q[3:0]), CH_CR, CH_LF};
  end

  // serial transmitter, one start, eight data lsb first, one stop
  logic                    busy_q, busy_d, txd_q, txd_d;
  logic [LINE_CHARS*8-1:0] line_q, line_d;
  logic [5:0]              chidx_q, chidx_d;
  logic [3:0]              bit_q, bit_d;
  logic [15:0]             baud_q, baud_d;
  logic [9:0]              frame_q, frame_d;
  always_comb begin
    busy_d  = busy_q;
    line_d  = line_q;
    chidx_d = chidx_q;
    bit_d   = bit_q;
    baud_d  = baud_q;
    frame_d = frame_q;
    if (!busy_q) begin
      if (snap_q) begin
        busy_d  = 1'b1;
        line_d  = line_v << 8;
        frame_d = {1'b1, line_v[LINE_CHARS*8-1 -: 8], 1'b0};
        chidx_d = 6'h00;
        bit_d   = 4'h0;
        baud_d  = 16'h0000;
      end
    end else if (baud_q == 16'(BAUD_DIV_P - 1)) begin
      baud_d = 16'h0000;
      if (bit_q == 4'(FRAME_BITS - 1)) begin
        bit_d   = 4'h0;
        chidx_d = chidx_q + 6'h01;
        frame_d = {1'b1, line_q[LINE_CHARS*8-1 -: 8], 1'b0};
        line_d  = line_q << 8;
        busy_d  = chidx_q != 6'(LINE_CHARS - 1);
      end else begin
        bit_d   = bit_q + 4'h1;
        frame_d = {1'b1, frame_q[9:1]};
      end
    end else begin
      baud_d = baud_q + 16'h0001;
    end
    txd_d = busy_d ? frame_d[0] : 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_q  <= 1'b0;
      line_q  <= '0;
      chidx_q <= 6'h00;
      bit_q   <= 4'h0;
      baud_q  <= 16'h0000;
      frame_q <= 10'h3FF;
      txd_q   <= 1'b1;
    end else begin
      busy_q  <= busy_d;
      line_q  <= line_d;
      chidx_q <= chidx_d;
      bit_q   <= bit_d;
      baud_q  <= baud_d;
      frame_q <= frame_d;
      txd_q   <= txd_d;
    end
  end
  assign txd = txd_q;

  // register slave: address and data taken in either order, one write and one read at a time
  logic              awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d, wr_go, ok;
  logic [AXI_AW-1:0] awa_q, awa_d, wa;
  logic [31:0]       wd_q, wd_d, wdx, rd_q, rd_d;
  logic [3:0]        ws_q, ws_d, wsx;
  logic [1:0]        br_q, br_d, rr_q, rr_d;
  logic [2:0]        ctrl_d;
  logic [15:0]       cycle_d;
  logic [31:0]       thr_d, c32;
  logic              aclr_d, sclr_d, dacwr_d;
  logic [13:0]       dacw_d;
  always_comb begin
    awh_d = awh_q | (axi_req.awvalid & ~awh_q & ~bv_q);
    awa_d = (axi_req.awvalid & ~awh_q & ~bv_q) ? axi_req.awaddr : awa_q;
    wh_d  = wh_q | (axi_req.wvalid & ~wh_q & ~bv_q);
    wd_d  = (axi_req.wvalid & ~wh_q & ~bv_q) ? axi_req.wdata : wd_q;
    ws_d  = (axi_req.wvalid & ~wh_q & ~bv_q) ? axi_req.wstrb : ws_q;
    wr_go = awh_q & wh_q & ~bv_q;
    wa    = awa_q;
    wdx   = wd_q;
    wsx   = ws_q;
    bv_d  = bv_q & ~axi_req.bready;
    br_d  = br_q;
    ctrl_d  = ctrl_q;
    cycle_d = cycle_q;
    thr_d   = thr_q;
    aclr_d  = 1'b0;
    sclr_d  = 1'b0;
    dacwr_d = 1'b0;
    dacw_d  = dacw_q;
    ok      = 1'b1;
    c32     = 32'h0000_0000;
    if (wr_go) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      unique case (wa)
        REG_CTRL:  begin
          c32    = merge({29'h0, ctrl_q}, wdx, wsx);
          ctrl_d = c32[2:0];
        end
        REG_CMD:   begin
          aclr_d = wsx[0] & wdx[CMD_ACLR];
          sclr_d = wsx[0] & wdx[CMD_SCLR];
        end
        REG_CYCLE: begin
          c32     = merge({16'h0, cycle_q}, wdx, wsx);
          cycle_d = c32[15:0];
        end
        REG_THR:   thr_d = merge(thr_q, wdx, wsx);
        REG_DAC:   begin
          c32     = merge({18'h0, dac_q}, wdx, wsx);
          dacw_d  = c32[13:0];
          dacwr_d = 1'b1;
        end
        REG_STAT, REG_MEAS: ok = 1'b1;
        default:   ok = 1'b0;
      endcase
      br_d = ok ? RESP_OKAY : RESP_SLV;
    end
    rv_d = rv_q & ~axi_req.rready;
    rd_d = rd_q;
    rr_d = rr_q;
    if (axi_req.arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      unique case (axi_req.araddr)
        REG_CTRL:  rd_d = {29'h0, ctrl_q};
        REG_CMD:   rd_d = 32'h0000_0000;
        REG_CYCLE: rd_d = {scnt_q, cycle_q};
        REG_THR:   rd_d = thr_q;
        REG_DAC:   rd_d = {18'h0, dac_q};
        REG_STAT:  rd_d = {ts_q, hcnt_q, 2'b00, alarm_q, state_q};
        REG_MEAS:  rd_d = {acc_q, freq_q};
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = RESP_SLV;
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      awh_q <= 1'b0; wh_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      awa_q <= '0; wd_q <= 32'h0; ws_q <= 4'h0; rd_q <= 32'h0;
      br_q <= RESP_OKAY; rr_q <= RESP_OKAY;
      ctrl_q <= CTRL_RST; cycle_q <= CYCLE_RST; thr_q <= THR_RST;
      aclr_q <= 1'b0; sclr_q <= 1'b0; dacwr_q <= 1'b0; dacw_q <= DAC_RST;
    end else begin
      awh_q <= awh_d; wh_q <= wh_d; bv_q <= bv_d; rv_q <= rv_d;
      awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d; rd_q <= rd_d;
      br_q <= br_d; rr_q <= rr_d;
      ctrl_q <= ctrl_d; cycle_q <= cycle_d; thr_q <= thr_d;
      aclr_q <= aclr_d; sclr_q <= sclr_d; dacwr_q <= dacwr_d; dacw_q <= dacw_d;
    end
  end
  always_comb begin
    axi_rsp.awready = ~awh_q & ~bv_q;
    axi_rsp.wready  = ~wh_q & ~bv_q;
    axi_rsp.bvalid  = bv_q;
    axi_rsp.bresp   = br_q;
    axi_rsp.arready = ~rv_q;
    axi_rsp.rvalid  = rv_q;
    axi_rsp.rdata   = rd_q;
    axi_rsp.rresp   = rr_q;
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_adjust;
    samp_q && cyc_end && state_q != ST_DISABLED && acc_n != 0;
  endsequence
  sequence s_quiet;
    samp_q && !cyc_end;
  endsequence
  chk_line_start: assert property (snap_q && !busy_q |=> busy_q ##1 !txd)
    else $error("status line did not start");
  chk_idle_high: assert property (!busy_q |-> txd)
    else $error("line not idle high");
  chk_alarm_held: assert property (!aclr_q |=> (alarm_q & $past(alarm_q)) == $past(alarm_q))
    else $error("latched alarm lost");
  chk_adj_marks: assert property (s_adjust |=> (size_q == CH_C || size_q == CH_F) && sign_q != CH_DOT)
    else $error("adjustment not flagged");
  chk_avg_dots: assert property (s_quiet |=> sign_q == CH_DOT && size_q == CH_DOT)
    else $error("marks not cleared while averaging");
  chk_vote_step: assert property ((s_quiet and !ctrl_q[CTRL_SUM]) |=>
    (acc_q - $past(acc_q) == 16'sh0001 || $past(acc_q) - acc_q == 16'sh0001 || acc_q == $past(acc_q)))
    else $error("voting step not one");
  chk_stamp_inc: assert property (samp_q |=> ts_q == $past(ts_q) + 16'h0001)
    else $error("timestamp not advanced");
  chk_hold_zero: assert property (state_q == ST_LOCKED ##1 state_q == ST_HOLDOVER |-> hcnt_q == 8'h00)
    else $error("holdover counter not zeroed");
  chk_gate_off: assert property (ctrl_q[CTRL_GATE] && state_q == ST_UNLOCKED |-> !ref_out_en)
    else $error("outputs on while unlocked");
  chk_manual_dac: assert property (state_q == ST_DISABLED && !dacwr_q |=> $stable(dac_q))
    else $error("dac moved in manual state");
  chk_step_size: assert property (s_adjust |=>
    (dac_q - $past(dac_q) <= STEP_COARSE || $past(dac_q) - dac_q <= STEP_COARSE))
    else $error("dac step too large");

endmodule // gps_fll_status_and_control

// ===== tb/fll_partner.sv
// pulse source, reference oscillator and status-line terminal model
`timescale 1ns/1ns
module fll_partner
  import fll_pkg::*;
#(
  parameter int unsigned BDIV = 4
) (
  // clock
  input  wire logic                    mclk,
  // serial line from the block
  input  wire logic                    txd,
  // timing pins
  output logic                         pps_pin,
  output logic                         osc_pin,
  // received line
  output logic [LINE_CHARS*8-1:0]      line_q,
  output int                           line_cnt,
  output int                           frame_err
);
  int unsigned tick_q;
  int          n_ch;
  logic [7:0]  ch;

  // pulse period 120 clocks, osc period 6: every window holds exactly 320 edges
  initial begin
    tick_q = 0;
    pps_pin = 1'b0;
    osc_pin = 1'b0;
    forever begin
      @(posedge mclk);
      tick_q <= tick_q + 1;
      pps_pin <= (tick_q % 120) < 4;
      osc_pin <= ((tick_q / 3) % 2) == 1;
    end
  end

  // mid-bit sampling, 8N1
  initial begin
    line_q = '0;
    line_cnt = 0;
    frame_err = 0;
    n_ch = 0;
    forever begin
      @(negedge txd);
      repeat (BDIV / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BDIV) @(posedge mclk);
        ch[i] = txd;
      end
      repeat (BDIV) @(posedge mclk);
      if (txd !== 1'b1) frame_err++;
      line_q = {line_q[LINE_CHARS*8-9:0], ch};
      n_ch++;
      if (ch == CH_LF) begin
        if (n_ch != LINE_CHARS) frame_err++;
        n_ch = 0;
        line_cnt++;
      end
    end
  end
endmodule // fll_partner

// ===== tb/test_gps_fll_status_and_control.sv
// self-checking bench of the frequency-locked-loop supervisor
`timescale 1ns/1ns
module test_gps_fll_status_and_control import fll_pkg::*;;
  logic                    mclk, resetn, pps_pin, osc_pin, ref_out_en, led_red, led_green, txd;
  axi_req_t                req;
  axi_rsp_t                rsp;
  logic [13:0]             dac_value, dac0;
  logic [LINE_CHARS*8-1:0] line_q;
  logic [31:0]             rd;
  logic [1:0]              rr;
  int                      line_cnt, frame_err, n_mismatch, checked;

  gps_fll_status_and_control #(.BAUD_DIV_P(4)) dut (.mclk(mclk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
    .pps_pin(pps_pin), .osc_pin(osc_pin), .dac_value(dac_value), .ref_out_en(ref_out_en), .led_red(led_red),
    .led_green(led_green), .txd(txd));
  fll_partner #(.BDIV(4)) far (.mclk(mclk), .txd(txd), .pps_pin(pps_pin), .osc_pin(osc_pin), .line_q(line_q),
    .line_cnt(line_cnt), .frame_err(frame_err));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ch(input int k);
    return line_q[(LINE_CHARS-1-k)*8 +: 8];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    chk(32'(rsp.bresp), 32'(RESP_OKAY));
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req.rready <= 1'b0;
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask

  // status read right after each line, before the next window closes
  task automatic wait_line();
    int n;
    n = line_cnt;
    while (line_cnt == n) @(posedge mclk);
    rdr(REG_STAT);
  endtask

  task automatic t_defaults();
    logic [7:0]  a [4] = '{REG_CTRL, REG_CYCLE, REG_THR, REG_DAC};
    logic [31:0] e [4] = '{32'(CTRL_RST), 32'(CYCLE_RST), THR_RST, 32'(DAC_RST)};
    for (int i = 0; i < 4; i++) begin
      rdr(a[i]);
      chk(rd, e[i]);
    end
    rdr(8'h1C);
    chk({rd[31:2], rr}, {30'h0, RESP_SLV});
    chk({30'h0, ref_out_en, txd}, 32'h3);
  endtask

  task automatic t_loop();
    logic [15:0] ts;
    wr(REG_CYCLE, 32'h1);
    wr(REG_THR, 32'h02080408);
    wait_line();
    chk(32'(rd[1:0]), 32'h1);
    chk({ch(0), ch(2), ch(10), ch(12)}, {CH_L, CH_DOT, CH_PLUS, CH_F});
    chk({ch(5), ch(6), ch(7), ch(8)}, "2001");
    chk({ch(4), 8'h0, ch(36), ch(37)}, {CH_0, 8'h0, CH_CR, CH_LF});
    chk(32'(dac_value), 32'h2001);
    wait_line();
    chk(32'(rd[15:0]), 32'h2);
    wait_line();
    chk(32'(rd[15:0]), 32'h102);
    ts = rd[31:16];
    wait_line();
    chk(32'(rd[5:0]), 32'h24);
    chk(32'(rd[31:16]), 32'(ts + 16'h1));
    chk({ch(0), ch(2), ch(36), 7'h0, led_green}, {CH_U, CH_H, CH_CR, 8'h0});
  endtask

  task automatic t_gate();
    wr(REG_CMD, 32'h1);
    rdr(REG_STAT);
    chk({28'h0, rd[5:2]}, 32'h0);
    chk(32'(led_red), 32'h0);
    wr(REG_CTRL, 32'h1);
    chk(32'(ref_out_en), 32'h0);
    wait_line();
    chk({ref_out_en, 29'h0, rd[1:0]}, {1'b1, 31'h1});
    chk(32'(ch(2)), 32'(CH_DOT));
  endtask

  task automatic t_modes();
    wr(REG_CYCLE, 32'h3);
    wait_line();
    rdr(REG_MEAS);
    chk(rd, 32'hFFFF_0140);
    chk(32'({ch(10), ch(12)}), 32'({CH_DOT, CH_DOT}));
    wr(REG_CTRL, 32'h3);
    wait_line();
    rdr(REG_MEAS);
    chk(rd, 32'h993F_0140);
    dac0 = dac_value;
    // back to voting so the sum stays clear of 16-bit wrap
    wr(REG_CTRL, 32'h1);
    wait_line();
    chk({ch(10), ch(12), 2'h0, dac_value}, {CH_PLUS, CH_C, 2'h0, dac0 + 14'h10});
    // manual state: dac only moves by a register write
    wr(REG_CTRL, 32'h4);
    wr(REG_DAC, 32'h1234);
    rdr(REG_DAC);
    chk(rd, 32'h1234);
    wait_line();
    chk({ch(0), 10'h0, dac_value}, {CH_D, 10'h0, 14'h1234});
  endtask

  // nine lines of about 1900 clocks each
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    n_mismatch = 0;
    checked = 0;
    resetn = 1'b0;
    req = '0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_defaults();
    t_loop();
    t_gate();
    t_modes();
    chk(32'(frame_err), 32'h0);
    finish_test();
  end
endmodule // test_gps_fll_status_and_control
